/* uart_status_pkg.sv */
// constants for the line/modem status block of a serial transceiver
// assumes an apb slave with 32-bit data and one 200 MHz clock
package uart_status_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_LINE_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_MODEM_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CONFIG        = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h14;
  // line status bits
  localparam int LS_READY   = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY  = 2;
  // modem control bits
  localparam int MC_DTR      = 0;
  localparam int MC_RTS      = 1;
  localparam int MC_AUX1     = 2;
  localparam int MC_AUX2     = 3;
  localparam int MC_LOOPBACK = 4;
  // config bits
  localparam int CFG_FIFO_MODE = 0;
  localparam int CFG_AUTO_CTS  = 7;
  // interrupt status bits
  localparam int IRQ_MODEM   = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_PARITY  = 2;
  // reset values
  localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET        = 8'h00;
  localparam logic [2:0] IRQ_RESET           = 3'h0;
  // receive fifo depth
  localparam int RX_DEPTH = 64;
endpackage

/* rx_fifo_store.sv */
// receive byte store with per-entry parity flag
// assumes push is never raised while full
`timescale 1ns/1ps
module rx_fifo_store #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // write side
  input  wire logic         push,
  input  wire logic [7:0]   pushData,
  input  wire logic         pushParity,
  // read side
  input  wire logic         pop,
  output logic [7:0]        headData,
  output logic              headParity,
  output logic [AW:0]       count
);
  typedef struct packed {
    logic [AW-1:0] wp;   // write pointer
    logic [AW-1:0] rp;   // read pointer
    logic [AW:0]   cnt;  // stored entries
  } ptr_t;
  ptr_t ptr;
  ptr_t next_ptr;
  logic [8:0] mem [DEPTH];  // data plus parity flag

  // pointer update; pop on empty is ignored
  always_comb begin
    next_ptr = ptr;
    if (push) begin
      next_ptr.wp = ptr.wp + 1'b1;
    end
    if (pop && ptr.cnt != '0) begin
      next_ptr.rp = ptr.rp + 1'b1;
    end
    next_ptr.cnt = ptr.cnt + (AW+1)'(push) - (AW+1)'(pop && ptr.cnt != '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= '0;
    end else begin
      ptr <= next_ptr;
    end
  end

  // storage has no reset; entries are only read once written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr.wp] <= {pushParity, pushData};
    end
  end

  assign headData   = mem[ptr.rp][7:0];
  assign headParity = mem[ptr.rp][8];
  assign count      = ptr.cnt;
endmodule

/* uart_line_modem_status.sv */
// line and modem status registers with apb slave and interrupt
// assumes receiver strobes one cycle per character; modem pins asynchronous
`timescale 1ns/1ps
module uart_line_modem_status
  import uart_status_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receiver side
  input  wire logic        rxDone,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxParityBad,
  output logic [7:0]       rxData,
  // transmitter side
  input  wire logic        txCharDone,
  output logic             txAllow,
  // modem pins, active low
  input  wire logic        ctsIn_n,
  input  wire logic        dsrIn_n,
  input  wire logic        riIn_n,
  input  wire logic        dcdIn_n,
  output logic             rtsOut_n,
  output logic             dtrOut_n,
  // interrupt
  output logic             irq
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [3:0]  sync1;      // first synchroniser stage
    logic [3:0]  sync2;      // second stage, {dcd,ri,dsr,cts} active high
    logic [3:0]  lineUp;     // upper modem status bits as last seen
    logic        primed;     // lineUp valid after reset release
    logic [3:0]  delta;      // change bits
    logic        parity;     // non-fifo parity flag
    logic        overrun;    // overrun flag
    logic [7:0]  shiftReg;   // receive shift register copy
    logic [7:0]  modemCtl;   // modem control register
    logic [7:0]  config_;    // fifo mode and auto cts
    logic [2:0]  irqStat;    // interrupt status, overrun and parity sticky, modem a level
    logic [2:0]  irqMask;    // interrupt mask
    logic        txGate;     // transmitter allowed
    logic [31:0] rdata;      // registered read data
    logic        ready;      // apb ready
    logic        err;        // apb error
    logic        irqOut;     // registered interrupt
    logic        rtsQ;       // registered rts pin
    logic        dtrQ;       // registered dtr pin
  } state_t;

  state_t s;
  state_t next_s;

  // fifo wiring
  logic          push;
  logic          pop;
  logic [7:0]    headData;
  logic          headParity;
  logic [AW:0]   count;

  logic          setup;       // apb setup phase
  logic          wr;          // write in setup phase
  logic          rdLine;      // line status read
  logic          rdModem;     // modem status read
  logic [3:0]    upNow;       // upper modem bits, loop-back applied
  logic [3:0]    events;      // detected change events
  logic          full;        // fifo full
  logic [7:0]    lineStatus;  // assembled line status
  logic [7:0]    modemStatus; // assembled modem status
  logic          parShown;    // reported parity error

  // change event on a status bit pair: either edge, or for ri the falling edge only
  function automatic logic [3:0] changeEvents(input logic [3:0] prev, input logic [3:0] cur);
    logic [3:0] e;
    e    = prev ^ cur;
    e[2] = prev[2] & ~cur[2];          // ri active high falling, pin 0->1
    return e;
  endfunction

  rx_fifo_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
    .clk        (clk),
    .rst_n      (rst_n),
    .push       (push),
    .pushData   (rxByte),
    .pushParity (rxParityBad),
    .pop        (pop),
    .headData   (headData),
    .headParity (headParity),
    .count      (count)
  );

  // apb decode; answers in the access cycle after setup, pready one cycle
  assign setup   = psel && !penable;
  assign wr      = setup && pwrite;
  assign rdLine  = setup && !pwrite && paddr == ADDR_LINE_STATUS;
  assign rdModem = setup && !pwrite && paddr == ADDR_MODEM_STATUS;
  assign full    = count == (AW+1)'(DEPTH);
  // overrun keeps the fifo intact
  assign push    = rxDone && !full;
  // data register read pops the head; sits at ADDR_CONFIG + 8'h10, above the interrupt mask
  assign pop     = setup && !pwrite && paddr == ADDR_CONFIG + 8'h10 && count != '0;

  // loop-back replaces pins with control bits
  assign upNow = s.modemCtl[MC_LOOPBACK] ?
                 {s.modemCtl[MC_AUX2], s.modemCtl[MC_AUX1],
                  s.modemCtl[MC_DTR], s.modemCtl[MC_RTS]} : s.sync2;
  assign events = s.primed ? changeEvents(s.lineUp, upNow) : 4'h0;

  // parity follows fifo head in fifo mode
  assign parShown = s.config_[CFG_FIFO_MODE] ? (count != '0 && headParity) : s.parity;
  // data ready reflects held bytes
  assign lineStatus = {5'h00, parShown, s.overrun, count != '0};
  // upper bits live, lower bits latched
  assign modemStatus = {upNow, s.delta};

  // next state
  always_comb begin
    next_s       = s;
    // two-flop synchronisers, pins inverted into the second stage
    next_s.sync1 = {dcdIn_n, riIn_n, dsrIn_n, ctsIn_n};
    next_s.sync2 = ~s.sync1;
    next_s.lineUp = upNow;
    next_s.primed = 1'b1;
    // receive errors
    if (rxDone && !full) begin
      next_s.parity = rxParityBad;
    end
    if (rdLine) begin
      next_s.parity  = 1'b0;
      next_s.overrun = 1'b0;
    end
    if (rxDone) begin
      next_s.shiftReg = rxByte;
      if (full) begin
        next_s.overrun = 1'b1;                              // set wins
      end
      if (rxParityBad && !full) begin
        next_s.parity = 1'b1;                               // set wins
      end
    end
    // change bits: read clears, new event still wins
    if (rdModem) begin
      next_s.delta = events;
    end else begin
      next_s.delta = s.delta | events;
    end
    // auto cts gates transmitter at character boundary
    if (!s.config_[CFG_AUTO_CTS] || upNow[0]) begin
      next_s.txGate = 1'b1;
    end else if (txCharDone || !s.txGate) begin
      next_s.txGate = 1'b0;
    end
    // sticky interrupt bits: write one clears, set wins
    if (wr && paddr == ADDR_IRQ_STATUS) begin
      next_s.irqStat = s.irqStat & ~pwdata[2:0];
    end
    next_s.irqStat[IRQ_OVERRUN] = next_s.irqStat[IRQ_OVERRUN] | (rxDone && full);
    next_s.irqStat[IRQ_PARITY]  = next_s.irqStat[IRQ_PARITY] | (push && rxParityBad);
    // modem bit is a level of the change bits
    next_s.irqStat[IRQ_MODEM]   = next_s.delta != 4'h0;
    // register writes
    if (wr && paddr == ADDR_MODEM_CONTROL) begin
      next_s.modemCtl = {3'h0, pwdata[4:0]};
    end
    if (wr && paddr == ADDR_CONFIG) begin
      next_s.config_ = {pwdata[CFG_AUTO_CTS], 6'h00, pwdata[CFG_FIFO_MODE]};
    end
    if (wr && paddr == ADDR_IRQ_MASK) begin
      next_s.irqMask = pwdata[2:0];
    end
    // apb answer
    next_s.ready = setup;
    next_s.err   = 1'b0;
    next_s.rdata = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        ADDR_LINE_STATUS:          next_s.rdata = {24'h000000, lineStatus};
        ADDR_MODEM_STATUS:         next_s.rdata = {24'h000000, modemStatus};
        ADDR_MODEM_CONTROL:        next_s.rdata = {24'h000000, s.modemCtl};
        ADDR_CONFIG:               next_s.rdata = {24'h000000, s.config_};
        ADDR_IRQ_STATUS:           next_s.rdata = {29'h0, s.irqStat};
        ADDR_IRQ_MASK:             next_s.rdata = {29'h0, s.irqMask};
        ADDR_CONFIG + 8'h10:       next_s.rdata = {24'h000000, headData};
        default:                   next_s.err   = 1'b1;   // unmapped
      endcase
    end
    next_s.irqOut = |(next_s.irqStat & next_s.irqMask);
    // pins driven inactive high in loop-back
    next_s.rtsQ = s.modemCtl[MC_LOOPBACK] | ~s.modemCtl[MC_RTS];
    next_s.dtrQ = s.modemCtl[MC_LOOPBACK] | ~s.modemCtl[MC_DTR];
  end

  // single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.sync1    <= 4'hF;             // pins idle high; avoids a false change after reset
      s.modemCtl <= MODEM_CONTROL_RESET;
      s.config_  <= CONFIG_RESET;
      s.irqStat  <= IRQ_RESET;
      s.irqMask  <= IRQ_RESET;
      s.txGate   <= 1'b1;
      s.rtsQ     <= 1'b1;
      s.dtrQ     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata   = s.rdata;
  assign pready   = s.ready;
  assign pslverr  = s.err;
  assign irq      = s.irqOut;
  assign txAllow  = s.txGate;
  assign rtsOut_n = s.rtsQ;
  assign dtrOut_n = s.dtrQ;
  assign rxData   = s.shiftReg;

  // checks
  chk_overrun_set: assert property (@(posedge clk) disable iff (!rst_n)
    rxDone && full |=> s.overrun)
    else $error("overrun not flagged");
  chk_fifo_intact: assert property (@(posedge clk) disable iff (!rst_n)
    rxDone && full && !pop |=> $stable(count))
    else $error("fifo changed on overrun");
  chk_ready_flag: assert property (@(posedge clk) disable iff (!rst_n)
    lineStatus[LS_READY] == (count != '0))
    else $error("data ready wrong");
  chk_delta_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rdModem && events == 4'h0 |=> s.delta == 4'h0)
    else $error("change bits not cleared");
  chk_modem_irq: assert property (@(posedge clk) disable iff (!rst_n)
    s.delta != 4'h0 && s.irqMask[IRQ_MODEM] && !rdModem
    && !(wr && paddr == ADDR_IRQ_MASK) |=> irq)
    else $error("modem interrupt missing");
  chk_loop_cts: assert property (@(posedge clk) disable iff (!rst_n)
    s.modemCtl[MC_LOOPBACK] |-> modemStatus[4] == s.modemCtl[MC_RTS])
    else $error("loop-back cts wrong");
  chk_ri_rise: assert property (@(posedge clk) disable iff (!rst_n)
    s.primed && !s.lineUp[2] && upNow[2] && !s.delta[2] |=> !s.delta[2])
    else $error("ri falling flagged");
  chk_cts_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    s.primed && s.lineUp[0] != upNow[0] |=> s.delta[0])
    else $error("cts change lost");
  chk_line_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rdLine && !rxDone |=> !s.overrun)
    else $error("overrun not cleared");
  chk_tx_pause: assert property (@(posedge clk) disable iff (!rst_n)
    s.config_[CFG_AUTO_CTS] && !upNow[0] && s.txGate && !txCharDone |=> txAllow)
    else $error("transmit cut mid character");
  cov_overrun: cover property (@(posedge clk) rxDone && full);
  cov_modem_read: cover property (@(posedge clk) rdModem && s.delta != 4'h0);
  cov_loopback: cover property (@(posedge clk) s.modemCtl[MC_LOOPBACK] && events != 4'h0);
  cov_pause: cover property (@(posedge clk) $fell(txAllow));
endmodule

/* modem_peer.sv */
// far-side modem model: drives the four modem pins, active low
// assumes the bench names the pattern it wants; slow mode lags three cycles
`timescale 1ns/1ps
module modem_peer (
  // clock
  input  wire logic       clk,
  // request from the bench
  input  wire logic [3:0] want,
  input  wire logic       slow,
  // modem pins {dcd, ri, dsr, cts}, active low
  output logic [3:0]      pins
);
  logic [3:0] lag1, lag2, lag3;  // delay line of a sluggish modem
  initial pins = 4'hF;
  // pins move only after an edge; holding cts high pauses the sender
  always @(posedge clk) begin
    lag1 <= want;
    lag2 <= lag1;
    lag3 <= lag2;
    pins <= slow ? lag3 : want;
  end
endmodule

/* uart_line_modem_status_bench.sv */
// self-checking bench: apb master, receiver and transmitter strobes, modem peer
// assumes a wait-free apb slave and pins synced in three edges
`timescale 1ns/1ps
module uart_line_modem_status_bench;
  import uart_status_pkg::*;
  localparam int DEP = 4;               // small fifo, overrun comes quickly
  logic        clk, rst_n;              // clock and reset
  logic        psel, penable, pwrite;   // apb request
  logic [7:0]  paddr;                   // apb address
  logic [31:0] pwdata, prdata, rd, r;   // apb data, captured read, random word
  logic        pready, pslverr, slv;    // apb answer
  logic        rxDone, rxParityBad;     // receiver strobe
  logic [7:0]  rxByte, rxData;          // receiver bytes
  logic        txCharDone, txAllow;     // transmitter handshake
  logic        rtsOut_n, dtrOut_n, irq; // outputs
  logic [3:0]  want, pins, o, n;        // modem pins {dcd, ri, dsr, cts}
  logic        slow;                    // peer answers late
  logic [7:0]  em;                      // expected modem status
  logic [7:0]  b [DEP+1];               // bytes sent in the overrun run
  logic [31:0] seed;                    // xorshift state
  int          n_errors, n_compared;    // verdict counters
  uart_line_modem_status #(.DEPTH(DEP)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxDone(rxDone), .rxByte(rxByte),
    .rxParityBad(rxParityBad), .rxData(rxData), .txCharDone(txCharDone),
    .txAllow(txAllow), .ctsIn_n(pins[0]), .dsrIn_n(pins[1]), .riIn_n(pins[2]),
    .dcdIn_n(pins[3]), .rtsOut_n(rtsOut_n), .dtrOut_n(dtrOut_n), .irq(irq));
  modem_peer peer (.clk(clk), .want(want), .slow(slow), .pins(pins));
  // free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // xorshift draw, fixed seed keeps runs repeatable
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected modem status: inverted pins over change bits, ri only on rise
  function automatic logic [7:0] expModem(input logic [3:0] a, input logic [3:0] z);
    return {~z, z[3] ^ a[3], ~a[2] & z[2], z[1] ^ a[1], z[0] ^ a[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one apb transfer; answer sampled at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one received character, strobe lasts a single cycle
  task automatic push(input logic [7:0] v, input logic bad);
    @(posedge clk);
    rxDone <= 1'b1;
    rxByte <= v;
    rxParityBad <= bad;
    @(posedge clk);
    rxDone <= 1'b0;
  endtask
  task automatic results();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: the whole run needs fewer than a thousand cycles
  initial begin
    wt(20000);
    n_errors++;
    results();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rxDone, rxByte, rxParityBad, txCharDone, slow} = '0;
    want = 4'hF;
    seed = 32'd97899;
    n_errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    wt(6);
    rst_n <= 1'b1;
    wt(4);
    apb(0, ADDR_MODEM_STATUS, 0);
    chk("modem reset", 8'h00, rd);
    apb(0, ADDR_LINE_STATUS, 0);
    chk("line reset", 3'h0, rd[2:0]);
    apb(0, 8'h20, 0);
    chk("unmapped", 1'b1, slv);
    apb(1, ADDR_IRQ_MASK, 32'h7);
    // pins: each toggled alone twice, then random patterns
    for (int i = 0; i < 16; i++) begin
      o = want;
      r = xs();
      n = (i < 8) ? (o ^ (4'h1 << (i % 4))) : r[3:0];
      slow <= i[0];
      want <= n;
      wt(12);
      em = expModem(o, n);
      chk("irq modem", |em[3:0], irq);
      apb(0, ADDR_MODEM_STATUS, 0);
      chk("modem status", em, rd);
      wt(2);
      chk("irq after read", 1'b0, irq);
      apb(0, ADDR_MODEM_STATUS, 0);
      chk("modem cleared", {~n, 4'h0}, rd);
    end
    // loop-back: upper bits follow modem control bits, pins ignored
    for (int i = 0; i < 6; i++) begin
      r = xs();
      apb(1, ADDR_MODEM_CONTROL, {27'h0, 1'b1, r[3:0]});
      wt(8);
      apb(0, ADDR_MODEM_STATUS, 0);
      chk("loop modem", {r[3], r[2], r[0], r[1]}, rd[7:4]);
      chk("loop pins", 2'b11, {rtsOut_n, dtrOut_n});
    end
    apb(1, ADDR_MODEM_CONTROL, 32'h3);
    wt(8);
    chk("rts dtr on", 2'b00, {rtsOut_n, dtrOut_n});
    apb(0, ADDR_MODEM_STATUS, 0);
    // receive flags: parity, ready, clear on read
    push(8'hA5, 1'b1);
    wt(1);
    apb(0, ADDR_LINE_STATUS, 0);
    chk("line parity", 3'h5, rd[2:0]);
    apb(0, ADDR_LINE_STATUS, 0);
    chk("line cleared", 3'h1, rd[2:0]);
    apb(0, 8'h1C, 0);
    chk("rx byte", 8'hA5, rd[7:0]);
    apb(0, ADDR_LINE_STATUS, 0);
    chk("line empty", 3'h0, rd[2:0]);
    // fill past full: last byte overruns, stored bytes survive
    for (int i = 0; i <= DEP; i++) begin
      r = xs();
      b[i] = r[7:0];
      push(b[i], 1'b0);
    end
    wt(1);
    chk("shift reg", b[DEP], rxData);
    apb(0, ADDR_LINE_STATUS, 0);
    chk("line overrun", 3'h3, rd[2:0]);
    apb(0, ADDR_IRQ_STATUS, 0);
    chk("irq status", 3'h6, rd[2:0]);
    chk("irq line", 1'b1, irq);
    apb(1, ADDR_IRQ_MASK, 32'h0);
    wt(2);
    chk("irq masked", 1'b0, irq);
    apb(1, ADDR_IRQ_MASK, 32'h7);
    apb(1, ADDR_IRQ_STATUS, 32'h6);
    wt(2);
    chk("irq cleared", 1'b0, irq);
    for (int i = 0; i < DEP; i++) begin
      apb(0, 8'h1C, 0);
      chk("fifo kept", b[i], rd[7:0]);
    end
    // fifo mode: parity flag belongs to the head entry
    apb(1, ADDR_CONFIG, 32'h1);
    push(8'h11, 1'b0);
    push(8'h22, 1'b1);
    wt(1);
    apb(0, ADDR_LINE_STATUS, 0);
    chk("head good", 3'h1, rd[2:0]);
    apb(0, 8'h1C, 0);
    apb(0, ADDR_LINE_STATUS, 0);
    chk("head bad", 3'h5, rd[2:0]);
    apb(0, 8'h1C, 0);
    // auto cts: pause after current character, resume on cts low
    apb(1, ADDR_CONFIG, 32'h80);
    want <= 4'hF;
    slow <= 1'b0;
    wt(8);
    chk("tx running", 1'b1, txAllow);
    @(posedge clk);
    txCharDone <= 1'b1;
    @(posedge clk);
    txCharDone <= 1'b0;
    wt(2);
    chk("tx paused", 1'b0, txAllow);
    want <= 4'hE;
    wt(8);
    chk("tx resumed", 1'b1, txAllow);
    results();
  end
endmodule
